// >>> hw/aclre_pkg.sv
// Package for the access-control matching rule evaluator: register map, field layout,
// reset values, timing counts and the packet header carrier.
// Assumes a 10 MHz core clock and an APB master with 32-bit data.
package aclre_pkg;

	localparam int CLK_PERIOD_NS = 100;
	localparam int MICROSECOND_NS = 1000;
	localparam int MILLISECOND_NS = 1000000;
	localparam int US_CYCLES = MICROSECOND_NS / CLK_PERIOD_NS;
	localparam int MS_CYCLES_DEFAULT = MILLISECOND_NS / CLK_PERIOD_NS;
	localparam int TICK_W = 14;

	localparam int NUM_PORTS = 6;
	localparam int NUM_RULES = 16;
	localparam int COUNT_W = 11;

	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_ACTION = 8'h04;
	localparam logic [7:0] ADDR_MAC_LOW = 8'h08;
	localparam logic [7:0] ADDR_MAC_HIGH = 8'h0C;
	localparam logic [7:0] ADDR_IPV4_VALUE = 8'h10;
	localparam logic [7:0] ADDR_IPV4_MASK = 8'h14;
	localparam logic [7:0] ADDR_PORTS = 8'h18;
	localparam logic [7:0] ADDR_PROTO_FLAGS = 8'h1C;
	localparam logic [7:0] ADDR_SELECT = 8'h20;
	localparam logic [7:0] ADDR_STATUS = 8'h24;
	localparam logic [7:0] ADDR_MASK = 8'h28;

	localparam logic [1:0] MODE_DISABLED = 2'h0;
	localparam logic [1:0] MODE_LAYER2 = 2'h1;
	localparam logic [1:0] MODE_LAYER3 = 2'h2;
	localparam logic [1:0] MODE_LAYER4 = 2'h3;

	localparam logic [1:0] SEL_00 = 2'h0;
	localparam logic [1:0] SEL_01 = 2'h1;
	localparam logic [1:0] SEL_10 = 2'h2;
	localparam logic [1:0] SEL_11 = 2'h3;

	localparam logic [1:0] PORT_CMP_OFF = 2'h0;
	localparam logic [1:0] PORT_CMP_EITHER = 2'h1;
	localparam logic [1:0] PORT_CMP_INSIDE = 2'h2;
	localparam logic [1:0] PORT_CMP_OUTSIDE = 2'h3;

	localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

	typedef struct packed {
		logic [1:0] rule_layer_mode;
		logic [1:0] compare_select;
		logic       source_select;
		logic       match_polarity;
		logic [1:0] port_compare_mode;
		logic       tcp_flag_match_en;
	} aclre_config_type;

	typedef struct packed {
		logic [1:0] priority_mode;
		logic [2:0] priority_value;
		logic       remark_enable;
		logic [2:0] remark_priority;
		logic [1:0] map_mode;
		logic       time_unit_select;
		logic       counter_algorithm;
	} aclre_action_type;

	typedef struct packed {
		logic        valid;
		logic        is_ipv4;
		logic        is_tcp;
		logic        is_udp;
		logic [2:0]  ingress_port;
		logic [47:0] dst_mac;
		logic [47:0] src_mac;
		logic [15:0] ethertype;
		logic [31:0] ip_src;
		logic [31:0] ip_dst;
		logic [7:0]  ip_protocol;
		logic [15:0] src_port;
		logic [15:0] dst_port;
		logic [31:0] tcp_sequence;
		logic [7:0]  tcp_flags;
	} aclre_header_type;

endpackage : aclre_pkg

// >>> hw/aclre_rule_eval.sv
// Evaluates one access-control matching rule against each parsed packet header.
// Assumes the parser presents one header per valid cycle and peer rule results alongside.
//
// Functional notes
// - Mode 00 disables the rule; it never reports a match.
// - Mode 01 layer 2 or counter, 10 layer 3 IPv4, 11 layer 4.
// - Layer 2 select 01 MAC only, 10 EtherType only, 11 both.
// - Layer 2 select 00 is count mode, testing MAC and EtherType together.
// - Source select 0 compares destination address, 1 compares source address.
// - Polarity 0 makes inequality true, polarity 1 makes equality true.
// - Count value is the 11 bits of priority, remark and map fields.
// - Time unit bit 0 counts microseconds, 1 counts milliseconds.
// - Algorithm 0 loads and decrements per unit, interrupting on expiry.
// - Algorithm 1 counts matched packets, interrupts at terminal count, then resets.
// - Layer 3 select 01 masked single address, 10 both addresses unmasked.
// - Rule address meets selected address for 01, source address for 10.
// - Mask bit 0 compares, 1 ignores; for 10 mask holds destination address.
// - Layer 4 select 00 protocol, 01 TCP ports, 10 UDP ports, 11 sequence.
// - Max and min ports bound ports; concatenated they form the sequence value.
// - Port compare 00 off, 01 either bound, 10 inside, 11 outside range.
// - Protocol compare checks the IPv4 protocol byte against the rule's byte.
// - TCP flag matching happens only with the flag enable bit set.
// - Flag bits with mask 0 are compared, mask 1 bits are ignored.
// - Rules chosen by the select vector are ANDed before the entry fires.
// - Count events on ports 0 to 5 raise a per-port interrupt with status and mask bits.
// - A count-mode rule never reports a forwarding match.
`timescale 1ns/10ps
`default_nettype none

module aclre_rule_eval
	import aclre_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYCLES_DEFAULT
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire aclre_header_type      header,
	input  wire logic [NUM_RULES-1:0]  peer_match,
	output logic                       rule_match,
	output logic                       match_valid,
	output logic                       entry_hit,
	output logic [NUM_PORTS-1:0]       port_irq
);

	aclre_config_type        config_reg;
	aclre_action_type        action_reg;
	logic [47:0]             mac_value;
	logic [15:0]             ethertype_value;
	logic [31:0]             ipv4_compare_value;
	logic [31:0]             ipv4_compare_mask;
	logic [15:0]             min_port;
	logic [15:0]             max_port;
	logic [7:0]              ip_protocol_value;
	logic [7:0]              tcp_flag_mask;
	logic [7:0]              tcp_flag_value;
	logic [NUM_RULES-1:0]    rule_select_vector;
	logic [3:0]              own_index;
	logic [NUM_PORTS-1:0]    irq_status;
	logic [NUM_PORTS-1:0]    irq_mask;
	logic [COUNT_W-1:0]      counter;
	logic                    armed;
	logic [TICK_W-1:0]       tick_count;
	logic                    unit_tick;
	logic [2:0]              last_port;
	logic                    count_event;
	logic [2:0]              event_port;
	logic                    wr_en;
	logic                    rd_en;
	logic                    addr_ok;
	logic [COUNT_W-1:0]      count_value;
	logic                    count_mode;
	logic                    l2_mac_eq;
	logic                    l2_type_eq;
	logic                    compare_true;
	logic                    compare_valid;
	logic                    eval_result;
	logic                    qualifying;
	logic [15:0]             sel_port;
	logic                    port_ok;
	logic                    flag_ok;
	logic [TICK_W-1:0]       unit_cycles;
	logic [NUM_RULES-1:0]    all_results;
	logic [NUM_PORTS-1:0]    port_event;

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign count_value = {action_reg.priority_mode, action_reg.priority_value,
		action_reg.remark_enable, action_reg.remark_priority, action_reg.map_mode};
	assign count_mode = (config_reg.rule_layer_mode == MODE_LAYER2) &&
		(config_reg.compare_select == SEL_00);

	always_comb begin
		case (paddr)
			ADDR_CONFIG, ADDR_ACTION, ADDR_MAC_LOW, ADDR_MAC_HIGH, ADDR_IPV4_VALUE,
			ADDR_IPV4_MASK, ADDR_PORTS, ADDR_PROTO_FLAGS, ADDR_SELECT, ADDR_STATUS,
			ADDR_MASK: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	assign pslverr = psel && penable && !addr_ok;

	// Configuration registers written by software.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_reg <= '0;
			action_reg <= '0;
			mac_value <= '0;
			ethertype_value <= '0;
			ipv4_compare_value <= RESET_VALUE;
			ipv4_compare_mask <= RESET_VALUE;
			min_port <= '0;
			max_port <= '0;
			ip_protocol_value <= '0;
			tcp_flag_mask <= '0;
			tcp_flag_value <= '0;
			rule_select_vector <= '0;
			own_index <= '0;
			irq_mask <= '0;
		end else if (wr_en) begin
			case (paddr)
				ADDR_CONFIG: config_reg <= pwdata[8:0];
				ADDR_ACTION: action_reg <= pwdata[12:0];
				ADDR_MAC_LOW: mac_value[31:0] <= pwdata;
				ADDR_MAC_HIGH: begin
					mac_value[47:32] <= pwdata[15:0];
					ethertype_value <= pwdata[31:16];
				end
				ADDR_IPV4_VALUE: ipv4_compare_value <= pwdata;
				ADDR_IPV4_MASK: ipv4_compare_mask <= pwdata;
				ADDR_PORTS: begin
					min_port <= pwdata[15:0];
					max_port <= pwdata[31:16];
				end
				ADDR_PROTO_FLAGS: begin
					ip_protocol_value <= pwdata[7:0];
					tcp_flag_mask <= pwdata[15:8];
					tcp_flag_value <= pwdata[23:16];
				end
				ADDR_SELECT: begin
					rule_select_vector <= pwdata[15:0];
					own_index <= pwdata[19:16];
				end
				ADDR_MASK: irq_mask <= pwdata[NUM_PORTS-1:0];
				default: ;
			endcase
		end
	end

	// Read data for the access phase.
	always_comb begin
		prdata = '0;
		if (rd_en) begin
			case (paddr)
				ADDR_CONFIG: prdata = {23'h000000, config_reg};
				ADDR_ACTION: prdata = {19'h00000, action_reg};
				ADDR_MAC_LOW: prdata = mac_value[31:0];
				ADDR_MAC_HIGH: prdata = {ethertype_value, mac_value[47:32]};
				ADDR_IPV4_VALUE: prdata = ipv4_compare_value;
				ADDR_IPV4_MASK: prdata = ipv4_compare_mask;
				ADDR_PORTS: prdata = {max_port, min_port};
				ADDR_PROTO_FLAGS: prdata = {8'h00, tcp_flag_value, tcp_flag_mask,
					ip_protocol_value};
				ADDR_SELECT: prdata = {12'h000, own_index, rule_select_vector};
				ADDR_STATUS: prdata = {12'h000, armed, counter, 2'h0, irq_status};
				ADDR_MASK: prdata = {26'h0000000, irq_mask};
				default: prdata = '0;
			endcase
		end
	end

	// Header comparisons.
	assign l2_mac_eq = (config_reg.source_select ? header.src_mac : header.dst_mac)
		== mac_value;
	assign l2_type_eq = header.ethertype == ethertype_value;
	assign sel_port = config_reg.source_select ? header.src_port : header.dst_port;

	always_comb begin
		case (config_reg.port_compare_mode)
			PORT_CMP_OFF: port_ok = 1'b1;
			PORT_CMP_EITHER: port_ok = (sel_port == max_port) || (sel_port == min_port);
			PORT_CMP_INSIDE: port_ok = (sel_port >= min_port) && (sel_port <= max_port);
			PORT_CMP_OUTSIDE: port_ok = (sel_port < min_port) || (sel_port > max_port);
			default: port_ok = 1'b0;
		endcase
	end

	assign flag_ok = !config_reg.tcp_flag_match_en ||
		(((header.tcp_flags ^ tcp_flag_value) & ~tcp_flag_mask) == 8'h00);

	always_comb begin
		compare_true = 1'b0;
		compare_valid = 1'b1;
		case (config_reg.rule_layer_mode)
			MODE_DISABLED: compare_valid = 1'b0;
			MODE_LAYER2: begin
				case (config_reg.compare_select)
					SEL_01: compare_true = l2_mac_eq;
					SEL_10: compare_true = l2_type_eq;
					default: compare_true = l2_mac_eq && l2_type_eq;
				endcase
			end
			MODE_LAYER3: begin
				compare_valid = header.is_ipv4;
				case (config_reg.compare_select)
					SEL_01: compare_true = (((config_reg.source_select ? header.ip_src :
						header.ip_dst) ^ ipv4_compare_value) & ~ipv4_compare_mask)
						== 32'h00000000;
					SEL_10: compare_true = (header.ip_src == ipv4_compare_value) &&
						(header.ip_dst == ipv4_compare_mask);
					default: compare_valid = 1'b0;
				endcase
			end
			MODE_LAYER4: begin
				compare_valid = header.is_ipv4;
				case (config_reg.compare_select)
					SEL_00: compare_true = header.ip_protocol == ip_protocol_value;
					SEL_01: compare_true = header.is_tcp && port_ok && flag_ok;
					SEL_10: compare_true = header.is_udp && port_ok;
					default: compare_true = header.is_tcp && flag_ok &&
						(header.tcp_sequence == {max_port, min_port});
				endcase
			end
			default: compare_valid = 1'b0;
		endcase
	end

	assign eval_result = compare_valid &&
		(config_reg.match_polarity ? compare_true : !compare_true);
	assign qualifying = header.valid && count_mode && eval_result;

	// Match result and entry combination toward the action logic.
	always_comb begin
		all_results = peer_match;
		all_results[own_index] = eval_result && !count_mode;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rule_match <= 1'b0;
			match_valid <= 1'b0;
			entry_hit <= 1'b0;
		end else begin
			match_valid <= header.valid;
			rule_match <= header.valid && eval_result && !count_mode;
			entry_hit <= header.valid && (rule_select_vector != 16'h0000) &&
				((all_results | ~rule_select_vector) == 16'hFFFF);
		end
	end

	// Time base for the countdown.
	assign unit_cycles = action_reg.time_unit_select ? TICK_W'(MS_CYCLES) :
		TICK_W'(US_CYCLES);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_count <= '0;
			unit_tick <= 1'b0;
		end else if (qualifying || !armed) begin
			tick_count <= '0;
			unit_tick <= 1'b0;
		end else if (tick_count == unit_cycles - TICK_W'(1)) begin
			tick_count <= '0;
			unit_tick <= 1'b1;
		end else begin
			tick_count <= tick_count + TICK_W'(1);
			unit_tick <= 1'b0;
		end
	end

	// Watchdog countdown or packet event counter.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter <= '0;
			armed <= 1'b0;
			count_event <= 1'b0;
			event_port <= '0;
			last_port <= '0;
		end else begin
			count_event <= 1'b0;
			if (!count_mode) begin
				counter <= '0;
				armed <= 1'b0;
			end else if (!action_reg.counter_algorithm) begin
				if (qualifying) begin
					counter <= count_value;
					armed <= 1'b1;
					last_port <= header.ingress_port;
				end else if (armed && unit_tick) begin
					if (counter <= COUNT_W'(1)) begin
						counter <= '0;
						armed <= 1'b0;
						count_event <= 1'b1;
						event_port <= last_port;
					end else begin
						counter <= counter - COUNT_W'(1);
					end
				end
			end else begin
				armed <= 1'b0;
				if (qualifying) begin
					if (counter + COUNT_W'(1) >= count_value) begin
						counter <= '0;
						count_event <= 1'b1;
						event_port <= header.ingress_port;
					end else begin
						counter <= counter + COUNT_W'(1);
					end
				end
			end
		end
	end

	// Per-port sticky status, write one to clear, set wins over clear.
	always_comb begin
		port_event = '0;
		if (count_event && (event_port < 3'(NUM_PORTS))) begin
			port_event[event_port] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= '0;
		end else if (wr_en && (paddr == ADDR_STATUS)) begin
			irq_status <= (irq_status & ~pwdata[NUM_PORTS-1:0]) | port_event;
		end else begin
			irq_status <= irq_status | port_event;
		end
	end

	assign port_irq = irq_status & irq_mask;

endmodule : aclre_rule_eval

`default_nettype wire

// >>> verif/aclre_rule_eval_assertions.sv
// Checker for the rule evaluator: packet timing, APB answers and interrupt holding.
// Assumes it is bound to the rule evaluator and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module aclre_rule_eval_assertions
	import aclre_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYCLES_DEFAULT
) (
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [7:0]           paddr,
	input wire logic [31:0]          pwdata,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	input wire aclre_header_type     header,
	input wire logic [NUM_RULES-1:0] peer_match,
	input wire logic                 rule_match,
	input wire logic                 match_valid,
	input wire logic                 entry_hit,
	input wire logic [NUM_PORTS-1:0] port_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc;
	assign acc = psel && penable;
	sequence s_pkt;
		header.valid ##1 match_valid;
	endsequence
	sequence s_quiet;
		!header.valid ##1 !match_valid;
	endsequence
	a_valid_follows: assert property (header.valid |-> s_pkt)
		else $error("Result strobe missing after a header.");
	a_quiet_idle: assert property (!header.valid |-> s_quiet)
		else $error("Result strobe without a header.");
	a_match_qualified: assert property (rule_match |-> match_valid)
		else $error("Match reported outside a result cycle.");
	a_hit_qualified: assert property (entry_hit |-> match_valid)
		else $error("Entry hit outside a result cycle.");
	a_zero_wait: assert property (acc |-> pready)
		else $error("Register access not answered at once.");
	a_unmapped_err: assert property (acc && paddr > ADDR_MASK |-> pslverr && prdata == 32'h0)
		else $error("Unmapped access not refused.");
	a_mapped_ok: assert property (acc && paddr <= ADDR_MASK && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("Mapped access refused.");
	a_read_idle: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
		else $error("Read data outside a read.");
	a_irq_sticky: assert property (port_irq != 0 && !(acc && pwrite)
		|=> (port_irq & $past(port_irq)) == $past(port_irq))
		else $error("Port interrupt dropped without a register write.");
endmodule : aclre_rule_eval_assertions
bind aclre_rule_eval aclre_rule_eval_assertions #(.MS_CYCLES(MS_CYCLES)) aclre_chk_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.header(header), .peer_match(peer_match), .rule_match(rule_match),
	.match_valid(match_valid), .entry_hit(entry_hit), .port_irq(port_irq)
);
`default_nettype wire

// >>> verif/aclre_parser_model.sv
// Model of the ingress parser: presents one header for one cycle per request.
// Assumes the bench raises requests just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module aclre_parser_model
	import aclre_pkg::*;
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             req,
	input  wire aclre_header_type req_hdr,
	output var aclre_header_type  header
);
	// Fields outside the valid cycle are inverted each cycle so stale data never matches.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			header <= '0;
		end else if (req) begin
			header <= req_hdr;
			header.valid <= 1'b1;
		end else begin
			header <= ~header;
			header.valid <= 1'b0;
		end
	end
endmodule : aclre_parser_model
`default_nettype wire

// >>> verif/tb.sv
// Testbench for the rule evaluator: registers over APB, matching modes and count modes.
// Assumes the parser model in front and a shortened millisecond count.
`timescale 1ns/10ps
`default_nettype none
module tb
	import aclre_pkg::*;
;
	localparam int MSC = 20;
	logic             pclk, presetn, psel, penable, pwrite, req, err;
	logic [7:0]       paddr;
	logic [31:0]      pwdata, prdata, rd;
	logic             pready, pslverr, rule_match, match_valid, entry_hit;
	logic [15:0]      peer_match;
	logic [5:0]       port_irq;
	aclre_header_type header, req_hdr, h;
	int               errors = 0, n_tests = 0, cycles = 0;

	aclre_rule_eval #(.MS_CYCLES(MSC)) aclre_rule_eval_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.header(header), .peer_match(peer_match), .rule_match(rule_match),
		.match_valid(match_valid), .entry_hit(entry_hit), .port_irq(port_irq));
	aclre_parser_model aclre_parser_model_i (
		.pclk(pclk), .presetn(presetn), .req(req), .req_hdr(req_hdr), .header(header));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic w(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : w

	task automatic pkt(input logic [15:0] peer, input logic m, input logic hit);
		@(posedge pclk);
		req <= 1'b1;
		req_hdr <= h;
		@(posedge pclk);
		req <= 1'b0;
		peer_match <= peer;
		@(posedge pclk);
		@(negedge pclk);
		chk({match_valid, rule_match, entry_hit}, {1'b1, m, hit});
	endtask : pkt

	task automatic cp(input logic [31:0] c, input logic m);
		// Codes list mode, select, source, polarity, port mode and flag enable from bit 0 up.
		w(ADDR_CONFIG, {23'h000000, c[1:0], c[3:2], c[4], c[5], c[7:6], c[8]});
		pkt(16'h0, m, 1'b0);
	endtask : cp

	function automatic logic [31:0] act(input logic [10:0] n, input logic tu, input logic ca);
		return {19'h00000, n, tu, ca};
	endfunction : act

	task automatic t_regs();
		apb(1'b0, ADDR_CONFIG, 32'h0);
		chk(rd, RESET_VALUE);
		w(ADDR_CONFIG, 32'h1FF);
		apb(1'b0, ADDR_CONFIG, 32'h0);
		chk(rd, 32'h1FF);
		apb(1'b0, 8'h40, 32'h0);
		chk({err, rd}, {1'b1, 32'h0});
	endtask : t_regs

	task automatic t_layer2();
		h.dst_mac = 48'h1122_3344_5566;
		h.src_mac = 48'hA0A0_A0A0_A0A0;
		h.ethertype = 16'h0800;
		w(ADDR_MAC_LOW, 32'h3344_5566);
		w(ADDR_MAC_HIGH, 32'h0800_1122);
		cp(32'h20, 1'b0);
		cp(32'h25, 1'b1);
		cp(32'h35, 1'b0);
		cp(32'h15, 1'b1);
		cp(32'h29, 1'b1);
		h.ethertype = 16'h86DD;
		cp(32'h2D, 1'b0);
	endtask : t_layer2

	task automatic t_layer3();
		h.is_ipv4 = 1'b1;
		h.ip_dst = 32'hC0A8_00FE;
		h.ip_src = 32'h0A00_0001;
		w(ADDR_IPV4_VALUE, 32'hC0A8_0001);
		w(ADDR_IPV4_MASK, 32'h0000_00FF);
		cp(32'h26, 1'b1);
		cp(32'h36, 1'b0);
		w(ADDR_IPV4_MASK, 32'h0);
		cp(32'h26, 1'b0);
		w(ADDR_IPV4_VALUE, 32'h0A00_0001);
		w(ADDR_IPV4_MASK, 32'hC0A8_00FE);
		cp(32'h2A, 1'b1);
		cp(32'h02, 1'b0);
		cp(32'h0E, 1'b0);
		h.ip_dst = 32'hC0A8_00FF;
		cp(32'h2A, 1'b0);
	endtask : t_layer3

	task automatic t_layer4();
		logic [3:0] pe;
		pe = 4'b0101;
		h.is_tcp = 1'b1;
		h.ip_protocol = 8'h06;
		h.dst_port = 16'd90;
		h.tcp_sequence = 32'h0064_0050;
		h.tcp_flags = 8'h13;
		w(ADDR_PORTS, 32'h0064_0050);
		w(ADDR_PROTO_FLAGS, 32'h0012_ED06);
		cp(32'h23, 1'b1);
		cp(32'h03, 1'b0);
		for (int i = 0; i < 4; i++) cp(32'h27 | (32'(i) << 6), pe[i]);
		cp(32'h2F, 1'b1);
		cp(32'h12F, 1'b1);
		h.tcp_flags = 8'h10;
		cp(32'h12F, 1'b0);
		cp(32'h2F, 1'b1);
		h.is_tcp = 1'b0;
		h.is_udp = 1'b1;
		cp(32'hAB, 1'b1);
		cp(32'hA7, 1'b0);
		h.dst_port = 16'd80;
		cp(32'h6B, 1'b1);
	endtask : t_layer4

	task automatic t_entry();
		w(ADDR_SELECT, 32'h0003_0009);
		pkt(16'h0001, 1'b1, 1'b1);
		pkt(16'h0008, 1'b1, 1'b0);
		w(ADDR_SELECT, 32'h0);
	endtask : t_entry

	task automatic t_count();
		h.ingress_port = 3'd2;
		h.ethertype = 16'h0800;
		w(ADDR_MASK, 32'h3F);
		w(ADDR_ACTION, act(11'd2, 1'b0, 1'b1));
		cp(32'h21, 1'b0);
		chk(port_irq, 6'h0);
		pkt(16'h0, 1'b0, 1'b0);
		@(negedge pclk);
		chk(port_irq, 6'h04);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd & 32'h3F, 32'h04);
		w(ADDR_STATUS, 32'h04);
		@(negedge pclk);
		chk(port_irq, 6'h0);
		w(ADDR_MASK, 32'h0);
		pkt(16'h0, 1'b0, 1'b0);
		pkt(16'h0, 1'b0, 1'b0);
		@(negedge pclk);
		chk(port_irq, 6'h0);
		w(ADDR_MASK, 32'h3F);
		@(negedge pclk);
		chk(port_irq, 6'h04);
	endtask : t_count

	task automatic t_timer();
		h.ingress_port = 3'd1;
		w(ADDR_ACTION, act(11'd3, 1'b0, 1'b0));
		repeat (40) @(negedge pclk);
		w(ADDR_STATUS, 32'h3F);
		for (int i = 0; i < 3; i++) begin
			pkt(16'h0, 1'b0, 1'b0);
			repeat (15) @(negedge pclk);
		end
		chk(port_irq, 6'h0);
		repeat (30) @(negedge pclk);
		chk(port_irq, 6'h02);
		w(ADDR_STATUS, 32'h3F);
		w(ADDR_ACTION, act(11'd5, 1'b1, 1'b0));
		pkt(16'h0, 1'b0, 1'b0);
		repeat (55) @(negedge pclk);
		chk(port_irq, 6'h0);
		repeat (55) @(negedge pclk);
		chk(port_irq, 6'h02);
	endtask : t_timer

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		peer_match = 16'h0;
		req = 1'b0;
		req_hdr = '0;
		h = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_layer2();
		t_layer3();
		t_layer4();
		t_entry();
		t_count();
		t_timer();
		finish_test();
	end

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			finish_test();
		end
	end
endmodule : tb
`default_nettype wire
